// *** sle_exec.sv ***
/*
 * Execution unit for stores, program-memory access, stack, I/O bit and
 * shift/flag instructions, driven one instruction at a time from an
 * Avalon-MM slave. Data memory, program memory and I/O space sit
 * outside on the same clock and return read data in the cycle the read
 * strobe is high.
 */
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Post-increment store writes source at pointer, then pointer plus one; two cycles.
// - Pre-decrement store decrements pointer first, writes at new address; two cycles.
// - Displaced store writes at pointer plus offset, pointer unchanged; two cycles.
// - Direct store writes source at constant address; two cycles, no flags.
// - Program byte load from Z into Rd or r0, optional Z increment; three cycles.
// - Push writes source onto stack in two cycles, flags unchanged.
// - Pop moves top stack byte into destination in two cycles.
// - I/O bit set forces selected bit to one in two cycles.
// - I/O bit clear forces selected bit to zero in two cycles.
// - Logical left shift fills bit zero, updates Z C N V, one cycle.
// - Logical right shift fills bit seven, updates Z C N V, one cycle.
// - Rotate left through carry, updates flags, one cycle.
// - Rotate right through carry, updates flags, one cycle.
// - Arithmetic right shift keeps sign bit, updates Z C N V, one cycle.
// - Bit store copies register bit into transfer flag, one cycle.
// - Bit load copies transfer flag into register bit, one cycle.
// - Indexed flag set and clear force chosen status bit, one cycle.
// - Dedicated per-flag set and clear alter only that flag, one cycle.
module sle_exec #(
  parameter logic [15:0] SP_INIT = sle_pkg::SP_RST
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [15:0] dm_addr,
  output logic      [7:0]  dm_wdata,
  output logic             dm_we,
  output logic             dm_re,
  input  wire logic [7:0]  dm_rdata,
  output logic      [5:0]  io_addr,
  output logic      [7:0]  io_wdata,
  output logic             io_we,
  output logic             io_re,
  input  wire logic [7:0]  io_rdata,
  output logic      [14:0] pm_addr,
  output logic      [15:0] pm_wdata,
  output logic             pm_we,
  output logic             pm_re,
  input  wire logic [15:0] pm_rdata,
  input  wire logic        pm_busy,
  output logic             instr_done
);
  import sle_pkg::*;

  sle_state_t  state_ff;
  logic [7:0]  gpr [32];
  logic [7:0]  status_register_ff;
  logic [15:0] sp_ff;
  logic [31:0] cmd_ff;
  logic [15:0] k_ff;
  logic [1:0]  cnt_ff;
  logic [15:0] ptr_new_ff;
  logic        zlsb_ff;
  logic [7:0]  cap_ff;
  logic [15:0] dm_addr_ff;
  logic [7:0]  dm_wdata_ff;
  logic        dm_we_ff;
  logic        dm_re_ff;
  logic [5:0]  io_addr_ff;
  logic [7:0]  io_wdata_ff;
  logic        io_we_ff;
  logic        io_re_ff;
  logic [14:0] pm_addr_ff;
  logic [15:0] pm_wdata_ff;
  logic        pm_we_ff;
  logic        pm_re_ff;
  logic [31:0] rdata_ff;
  logic        rd_ack_ff;
  logic        done_ff;

  logic        busy;
  logic        start;
  logic        bus_wr;
  logic        last;
  logic [5:0]  w_op;
  logic [4:0]  w_rr;
  logic [1:0]  w_ptr;
  logic [1:0]  w_mode;
  logic [15:0] w_p;
  logic [5:0]  op_ff;
  logic [4:0]  rd_ff;
  logic [4:0]  rr_ff;
  logic [2:0]  bit_ff;
  logic [1:0]  mode_ff;
  logic [7:0]  mask;
  logic [7:0]  sh_res;
  logic        sh_c;
  logic        is_shift;
  logic        wr_rd_en;
  logic [4:0]  wr_rd_idx;
  logic [7:0]  wr_rd_val;
  logic        wr_ptr_en;
  logic [4:0]  wr_ptr_base;
  logic [7:0]  nxt_status_register;

  function automatic logic [15:0] ptr_of(input logic [1:0] sel);
    logic [4:0] b;
    b = sle_ptr_base(sel);
    return {gpr[b + 5'h1], gpr[b]};
  endfunction

  assign busy     = (state_ff != SLE_IDLE);
  assign bus_wr   = avs_write && !busy;
  assign start    = bus_wr && (avs_address == OFS_CMD) && avs_byteenable[0];
  assign w_op     = avs_writedata[F_OP +: 6];
  assign w_rr     = avs_writedata[F_RR +: 5];
  assign w_ptr    = avs_writedata[F_PTR +: 2];
  assign w_mode   = avs_writedata[F_MODE +: 2];
  assign w_p      = ptr_of(w_ptr);
  assign op_ff    = cmd_ff[F_OP +: 6];
  assign rd_ff    = cmd_ff[F_RD +: 5];
  assign rr_ff    = cmd_ff[F_RR +: 5];
  assign bit_ff   = cmd_ff[F_BIT +: 3];
  assign mode_ff  = cmd_ff[F_MODE +: 2];
  assign mask     = 8'h01 << bit_ff;
  assign is_shift = (op_ff >= OP_LSL) && (op_ff <= OP_ASR);
  // Program store holds its last cycle until the programming logic is free
  assign last     = (state_ff == SLE_EXEC) && (cnt_ff == CYC_ONE)
                    && !((op_ff == OP_SPM) && pm_busy);

  // Writes stall while an instruction runs; reads take one wait cycle
  assign avs_waitrequest = (avs_read && !rd_ack_ff) || (avs_write && busy);
  assign avs_readdata    = rdata_ff;
  assign instr_done      = done_ff;
  assign dm_addr  = dm_addr_ff;
  assign dm_wdata = dm_wdata_ff;
  assign dm_we    = dm_we_ff;
  assign dm_re    = dm_re_ff;
  assign io_addr  = io_addr_ff;
  assign io_wdata = io_wdata_ff;
  assign io_we    = io_we_ff;
  assign io_re    = io_re_ff;
  assign pm_addr  = pm_addr_ff;
  assign pm_wdata = pm_wdata_ff;
  assign pm_we    = pm_we_ff;
  assign pm_re    = pm_re_ff;

  sle_shift_unit u_shift (
    .kind  (3'(op_ff - OP_LSL)),
    .val   (gpr[rd_ff]),
    .c_in  (status_register_ff[FL_C]),
    .res   (sh_res),
    .c_out (sh_c)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= SLE_IDLE;
      cnt_ff   <= 2'h0;
      cmd_ff   <= 32'h0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= last;
      case (state_ff)
        SLE_IDLE: begin
          if (start) begin
            state_ff <= SLE_EXEC;
            cmd_ff   <= avs_writedata;
            cnt_ff   <= sle_cycles(w_op);
          end
        end
        SLE_EXEC: begin
          if (last) begin
            state_ff <= SLE_IDLE;
          end else if (cnt_ff != CYC_ONE) begin
            cnt_ff <= cnt_ff - 2'h1;
          end
        end
        default: state_ff <= SLE_IDLE;
      endcase
    end
  end

  // Data memory port: requests leave on the start edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dm_addr_ff  <= 16'h0;
      dm_wdata_ff <= 8'h0;
      dm_we_ff    <= 1'b0;
      dm_re_ff    <= 1'b0;
      ptr_new_ff  <= 16'h0;
    end else begin
      dm_we_ff <= 1'b0;
      dm_re_ff <= 1'b0;
      if (start) begin
        dm_wdata_ff <= gpr[w_rr];
        ptr_new_ff  <= w_p;
        case (w_op)
          OP_ST: begin
            dm_we_ff <= 1'b1;
            if (w_mode == MODE_PRE) begin
              dm_addr_ff <= w_p - 16'h1;
              ptr_new_ff <= w_p - 16'h1;
            end else begin
              dm_addr_ff <= w_p;
              ptr_new_ff <= (w_mode == MODE_POST) ? w_p + 16'h1 : w_p;
            end
          end
          OP_STD: begin
            dm_we_ff   <= 1'b1;
            dm_addr_ff <= w_p + {10'h0, avs_writedata[F_Q +: 6]};
          end
          OP_STS: begin
            dm_we_ff   <= 1'b1;
            dm_addr_ff <= k_ff;
          end
          OP_PUSH: begin
            dm_we_ff   <= 1'b1;
            dm_addr_ff <= sp_ff;
          end
          OP_POP: begin
            dm_re_ff   <= 1'b1;
            dm_addr_ff <= sp_ff + 16'h1;
          end
          OP_LPM: ptr_new_ff <= ptr_of(PTR_Z) + 16'h1;
          default: dm_addr_ff <= dm_addr_ff;
        endcase
      end
    end
  end

  // I/O port, with a read-modify-write for the bit set and clear forms
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      io_addr_ff  <= 6'h0;
      io_wdata_ff <= 8'h0;
      io_we_ff    <= 1'b0;
      io_re_ff    <= 1'b0;
    end else begin
      io_we_ff <= 1'b0;
      io_re_ff <= 1'b0;
      if (start) begin
        io_addr_ff  <= k_ff[5:0];
        io_wdata_ff <= gpr[w_rr];
        io_we_ff    <= (w_op == OP_OUT);
        io_re_ff    <= (w_op == OP_IN) || (w_op == OP_SBI) || (w_op == OP_CBI);
      end else if (io_re_ff && (op_ff == OP_SBI)) begin
        io_we_ff    <= 1'b1;
        io_wdata_ff <= io_rdata | mask;
      end else if (io_re_ff && (op_ff == OP_CBI)) begin
        io_we_ff    <= 1'b1;
        io_wdata_ff <= io_rdata & ~mask;
      end
    end
  end

  // Program memory port; word address from Z, byte chosen by its lsb
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pm_addr_ff  <= 15'h0;
      pm_wdata_ff <= 16'h0;
      pm_we_ff    <= 1'b0;
      pm_re_ff    <= 1'b0;
      zlsb_ff     <= 1'b0;
    end else begin
      pm_we_ff <= 1'b0;
      pm_re_ff <= 1'b0;
      if (start) begin
        pm_addr_ff  <= 15'(ptr_of(PTR_Z) >> 1);
        zlsb_ff     <= gpr[BASE_Z][0];
        pm_wdata_ff <= {gpr[5'h1], gpr[5'h0]};
        pm_we_ff    <= (w_op == OP_SPM);
        pm_re_ff    <= (w_op == OP_LPM);
      end
    end
  end

  // Read data capture for pop and program loads
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cap_ff <= 8'h0;
    end else if (dm_re_ff) begin
      cap_ff <= dm_rdata;
    end else if (pm_re_ff) begin
      cap_ff <= zlsb_ff ? pm_rdata[15:8] : pm_rdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sp_ff <= SP_INIT;
    end else if (bus_wr && (avs_address == OFS_SP)) begin
      if (avs_byteenable[0]) sp_ff[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) sp_ff[15:8] <= avs_writedata[15:8];
    end else if (start && (w_op == OP_PUSH)) begin
      sp_ff <= sp_ff - 16'h1;
    end else if (start && (w_op == OP_POP)) begin
      sp_ff <= sp_ff + 16'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      k_ff <= 16'h0;
    end else if (bus_wr && (avs_address == OFS_CONST)) begin
      if (avs_byteenable[0]) k_ff[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) k_ff[15:8] <= avs_writedata[15:8];
    end
  end

  // Register file write-back, all on the last instruction cycle
  always_comb begin
    wr_rd_en    = 1'b0;
    wr_rd_idx   = rd_ff;
    wr_rd_val   = cap_ff;
    wr_ptr_en   = 1'b0;
    wr_ptr_base = sle_ptr_base(cmd_ff[F_PTR +: 2]);
    if (last) begin
      case (op_ff)
        OP_ST: wr_ptr_en = (mode_ff != MODE_PLAIN);
        OP_LPM: begin
          wr_rd_en    = 1'b1;
          wr_rd_idx   = (mode_ff == MODE_PLAIN) ? 5'h0 : rd_ff;
          wr_ptr_en   = (mode_ff == MODE_POST);
          wr_ptr_base = BASE_Z;
        end
        OP_IN: begin
          wr_rd_en  = 1'b1;
          wr_rd_val = io_rdata;
        end
        OP_POP: wr_rd_en = 1'b1;
        OP_BLD: begin
          wr_rd_en  = 1'b1;
          wr_rd_val = status_register_ff[FL_T] ? (gpr[rd_ff] | mask) : (gpr[rd_ff] & ~mask);
        end
        default: begin
          wr_rd_en  = is_shift;
          wr_rd_val = sh_res;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++) gpr[i] <= 8'h0;
    end else if (bus_wr && avs_address[7] && avs_byteenable[0]) begin
      gpr[avs_address[6:2]] <= avs_writedata[7:0];
    end else begin
      if (wr_rd_en) gpr[wr_rd_idx] <= wr_rd_val;
      if (wr_ptr_en) begin
        gpr[wr_ptr_base]        <= ptr_new_ff[7:0];
        gpr[wr_ptr_base + 5'h1] <= ptr_new_ff[15:8];
      end
    end
  end

  // Status register; stores, stack, I/O and loads leave it alone
  always_comb begin
    nxt_status_register = status_register_ff;
    if (last) begin
      if (is_shift) begin
        nxt_status_register[FL_Z] = (sh_res == 8'h00);
        nxt_status_register[FL_C] = sh_c;
        nxt_status_register[FL_N] = sh_res[7];
        nxt_status_register[FL_V] = sh_res[7] ^ sh_c;
      end else if (op_ff == OP_BST) begin
        nxt_status_register[FL_T] = gpr[rr_ff][bit_ff];
      end else if (op_ff == OP_FLAG_SET_INDEXED) begin
        nxt_status_register[bit_ff] = 1'b1;
      end else if (op_ff == OP_FLAG_CLEAR_INDEXED) begin
        nxt_status_register[bit_ff] = 1'b0;
      end else if (op_ff[5:3] == OP_SEF[5:3]) begin
        nxt_status_register[op_ff[2:0]] = 1'b1;
      end else if (op_ff[5:3] == OP_CLF[5:3]) begin
        nxt_status_register[op_ff[2:0]] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_register_ff <= STATUS_REGISTER_RST;
    end else if (bus_wr && (avs_address == OFS_STAT) && avs_byteenable[1]) begin
      status_register_ff <= avs_writedata[STAT_STATUS_REGISTER +: 8];
    end else begin
      status_register_ff <= nxt_status_register;
    end
  end

  // Read path: one wait cycle so read data comes from a flip-flop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_ff  <= 32'h0;
      rd_ack_ff <= 1'b0;
    end else begin
      rd_ack_ff <= avs_read && !rd_ack_ff;
      if (avs_read && !rd_ack_ff) begin
        if (avs_address[7]) begin
          rdata_ff <= {24'h0, gpr[avs_address[6:2]]};
        end else begin
          case (avs_address)
            OFS_CMD:   rdata_ff <= cmd_ff;
            OFS_CONST: rdata_ff <= {16'h0, k_ff};
            OFS_STAT:  rdata_ff <= {16'h0, status_register_ff, 7'h0, busy};
            OFS_SP:    rdata_ff <= {16'h0, sp_ff};
            default:   rdata_ff <= 32'h0;
          endcase
        end
      end
    end
  end

  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Pointer pair is written at the edge ending the last cycle, seen one edge later
  store_post_a: assert property (start && w_op == OP_ST && w_mode == MODE_POST |-> ##3
    ptr_of($past(w_ptr, 3)) == $past(w_p, 3) + 16'h1) else $error("post-increment pointer wrong");
  store_pre_a: assert property (start && w_op == OP_ST && w_mode == MODE_PRE |=>
    dm_we && dm_addr == $past(w_p) - 16'h1) else $error("pre-decrement address wrong");
  store_disp_a: assert property (start && w_op == OP_STD |=> dm_we ##1 !dm_we
    ##1 !busy) else $error("displaced store timing wrong");
  store_direct_a: assert property (start && w_op == OP_STS |=> dm_we && dm_addr == $past(k_ff)
    ##1 busy && !dm_we ##1 !busy) else $error("direct store wrong");
  prog_load_a: assert property (start && w_op == OP_LPM |=> busy[*3] ##1 !busy)
    else $error("program load not three cycles");
  push_sp_a: assert property (start && w_op == OP_PUSH |=>
    sp_ff == $past(sp_ff) - 16'h1 && dm_addr == $past(sp_ff) && status_register_ff == $past(status_register_ff))
    else $error("push wrong");
  pop_read_a: assert property (start && w_op == OP_POP |=> dm_re ##1 !dm_re && busy
    ##1 !busy) else $error("pop timing wrong");
  io_set_a: assert property (io_we && op_ff == OP_SBI |->
    io_wdata == ($past(io_rdata) | mask)) else $error("bit set data wrong");
  io_clear_a: assert property (io_we && op_ff == OP_CBI |-> ##1 !busy)
    else $error("bit clear not finished in two cycles");
  shift_flags_a: assert property (last && is_shift |=> status_register_ff[FL_Z] == (gpr[$past(rd_ff)] == 8'h00)
    && status_register_ff[FL_N] == gpr[$past(rd_ff)][7]) else $error("shift flags wrong");
  bit_store_a: assert property (last && op_ff == OP_BST |=>
    status_register_ff[FL_T] == $past(gpr[rr_ff][bit_ff])) else $error("transfer flag not loaded");
  flag_only_a: assert property (last && op_ff[5:4] == 2'h2 |=>
    ((status_register_ff ^ $past(status_register_ff)) & ~(8'h01 << $past(op_ff[2:0]))) == 8'h00)
    else $error("dedicated flag op touched other bits");

  store_seen_c: cover property (start && w_op == OP_ST ##2 !busy);
  load_seen_c: cover property (last && op_ff == OP_LPM);
  io_rmw_c: cover property (io_we && op_ff == OP_SBI);
  bus_read_c: cover property (avs_read && !avs_waitrequest);
endmodule

`default_nettype wire

// *** sle_pkg.sv ***
/*
 * Shared constants for the store/load/bit execution unit, plus the
 * shift and rotate datapath that the unit instantiates.
 * Assumes a single clock domain and the register map defined here.
 */
`timescale 1ns/1ps
`default_nettype none

package sle_pkg;
  // Register map, byte addresses on the Avalon slave
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_CONST = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_SP    = 8'h0c;
  localparam logic [7:0] OFS_GPR   = 8'h80;

  // Command word and status word field positions
  localparam int F_OP   = 0;
  localparam int F_RD   = 6;
  localparam int F_RR   = 11;
  localparam int F_BIT  = 16;
  localparam int F_Q    = 19;
  localparam int F_PTR  = 25;
  localparam int F_MODE = 27;
  localparam int STAT_BUSY = 0;
  localparam int STAT_STATUS_REGISTER = 8;

  // Reset values
  localparam logic [15:0] SP_RST   = 16'h0000;
  localparam logic [7:0]  STATUS_REGISTER_RST = 8'h00;

  // Status register bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  // Operation codes
  localparam logic [5:0] OP_ST   = 6'h00;
  localparam logic [5:0] OP_STD  = 6'h01;
  localparam logic [5:0] OP_STS  = 6'h02;
  localparam logic [5:0] OP_LPM  = 6'h03;
  localparam logic [5:0] OP_SPM  = 6'h04;
  localparam logic [5:0] OP_IN   = 6'h05;
  localparam logic [5:0] OP_OUT  = 6'h06;
  localparam logic [5:0] OP_PUSH = 6'h07;
  localparam logic [5:0] OP_POP  = 6'h08;
  localparam logic [5:0] OP_SBI  = 6'h09;
  localparam logic [5:0] OP_CBI  = 6'h0a;
  localparam logic [5:0] OP_LSL  = 6'h0b;
  localparam logic [5:0] OP_LSR  = 6'h0c;
  localparam logic [5:0] OP_ROL  = 6'h0d;
  localparam logic [5:0] OP_ROR  = 6'h0e;
  localparam logic [5:0] OP_ASR  = 6'h0f;
  localparam logic [5:0] OP_BST  = 6'h10;
  localparam logic [5:0] OP_BLD  = 6'h11;
  localparam logic [5:0] OP_FLAG_SET_INDEXED = 6'h12;
  localparam logic [5:0] OP_FLAG_CLEAR_INDEXED = 6'h13;
  localparam logic [5:0] OP_SEF  = 6'h20;
  localparam logic [5:0] OP_CLF  = 6'h28;

  // Shift kinds, in the same order as the shift op codes
  localparam logic [2:0] SH_LSL = 3'h0;
  localparam logic [2:0] SH_LSR = 3'h1;
  localparam logic [2:0] SH_ROL = 3'h2;
  localparam logic [2:0] SH_ROR = 3'h3;
  localparam logic [2:0] SH_ASR = 3'h4;

  // Pointer pairs and addressing modes
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [4:0] BASE_X = 5'h1a;
  localparam logic [4:0] BASE_Y = 5'h1c;
  localparam logic [4:0] BASE_Z = 5'h1e;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST  = 2'h1;
  localparam logic [1:0] MODE_PRE   = 2'h2;

  // Cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [1:0] {
    SLE_IDLE = 2'b01,
    SLE_EXEC = 2'b10
  } sle_state_t;

  function automatic logic [1:0] sle_cycles(input logic [5:0] op);
    case (op)
      OP_LPM: return CYC_THREE;
      OP_ST, OP_STD, OP_STS, OP_PUSH, OP_POP, OP_SBI, OP_CBI: return CYC_TWO;
      default: return CYC_ONE;
    endcase
  endfunction

  function automatic logic [4:0] sle_ptr_base(input logic [1:0] sel);
    case (sel)
      PTR_X:   return BASE_X;
      PTR_Y:   return BASE_Y;
      default: return BASE_Z;
    endcase
  endfunction
endpackage

module sle_shift_unit (
  input  wire logic [2:0] kind,
  input  wire logic [7:0] val,
  input  wire logic       c_in,
  output logic      [7:0] res,
  output logic            c_out
);
  import sle_pkg::*;

  always_comb begin
    res   = val;
    c_out = c_in;
    case (kind)
      SH_LSL: begin
        res   = {val[6:0], 1'b0};
        c_out = val[7];
      end
      SH_LSR: begin
        res   = {1'b0, val[7:1]};
        c_out = val[0];
      end
      SH_ROL: begin
        res   = {val[6:0], c_in};
        c_out = val[7];
      end
      SH_ROR: begin
        res   = {c_in, val[7:1]};
        c_out = val[0];
      end
      SH_ASR: begin
        res   = {val[7], val[7:1]};
        c_out = val[0];
      end
      default: begin
        res   = val;
        c_out = c_in;
      end
    endcase
  end
endmodule

`default_nettype wire

// *** sle_tb.sv ***
/*
 * Self-checking bench for sle_exec: Avalon-MM register access, stores,
 * I/O bit ops, shifts and status flag instructions.
 * Assumes sle_pkg is compiled first; memories answer with fixed data.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import sle_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] dm_addr;
  logic [7:0]  dm_wdata;
  logic        dm_we;
  logic [7:0]  io_wdata;
  logic        io_we;
  logic        instr_done;
  int          n_done = 0;
  int          n_instr = 0;
  logic [15:0] seen_addr;
  logic [7:0]  seen_data;
  logic [7:0]  seen_io;
  logic [31:0] rv;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #10 clk_sys = ~clk_sys;

  sle_exec sle_exec_i (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(), .dm_rdata(8'h3c),
    .io_addr(), .io_wdata(io_wdata), .io_we(io_we), .io_re(), .io_rdata(8'h10),
    .pm_addr(), .pm_wdata(), .pm_we(), .pm_re(), .pm_rdata(16'hc35a), .pm_busy(1'b0),
    .instr_done(instr_done));

  // Strobes stand one cycle, so capture them at the edge
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (instr_done === 1'b1) n_done <= n_done + 1;
    if (dm_we) begin
      seen_addr <= dm_addr;
      seen_data <= dm_wdata;
    end
    if (io_we) begin
      seen_io <= io_wdata;
    end
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Issue one command word and poll busy until it clears
  task automatic go(input logic [31:0] c);
    n_instr = n_instr + 1;
    wr(OFS_CMD, c);
    do rd(OFS_STAT, rv); while (rv[STAT_BUSY] !== 1'b0);
  endtask

  task automatic run(input logic [5:0] op, input int r, input int b, input int p,
                     input int m);
    logic [31:0] c;
    c = 32'(op) | (32'(r) << F_RD) | (32'(r) << F_RR) | (32'(b) << F_BIT);
    c = c | (32'(p) << F_PTR) | (32'(m) << F_MODE);
    go(c);
  endtask

  task automatic status_register(input logic [7:0] exp);
    rd(OFS_STAT, rv);
    chk({24'h0, rv[15:8]}, {24'h0, exp});
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    wr(OFS_GPR + 8'h14, 32'ha5);
    wr(OFS_GPR + 8'h70, 32'h00);
    wr(OFS_GPR + 8'h74, 32'h01);
    run(OP_ST, 5, 0, 1, 1);                         // Post-increment
    chk({seen_addr, seen_data}, 32'h0100a5);        // Store at old Y
    rd(OFS_GPR + 8'h70, rv);
    chk(rv, 32'h01);                                // Y low byte bumped
    run(OP_ST, 5, 0, 1, 2);                         // Pre-decrement
    chk({seen_addr, seen_data}, 32'h0100a5);        // Store at new Y
    rd(OFS_GPR + 8'h70, rv);
    chk(rv, 32'h00);                                // Y back to start
    wr(OFS_CONST, 32'h0234);
    run(OP_STS, 5, 0, 0, 0);                        // Direct address
    chk({seen_addr, seen_data}, 32'h0234a5);        // Constant address
    status_register(8'h00);                                    // Stores leave flags
    wr(OFS_CONST, 32'h12);
    run(OP_SBI, 5, 2, 0, 0);                        // Set bit two
    chk({24'h0, seen_io}, 32'h14);                  // Only bit two added
    run(OP_CBI, 5, 4, 0, 0);                        // Clear bit four
    chk({24'h0, seen_io}, 32'h00);                  // Only bit four removed
    run(OP_LSL, 5, 0, 0, 0);                        // Shift left
    rd(OFS_GPR + 8'h14, rv);
    chk(rv, 32'h4a);                                // Zero into bit zero
    status_register(8'h09);                                    // Carry and V=N^C
    run(OP_BST, 5, 1, 0, 0);                        // Bit one to transfer
    status_register(8'h49);                                    // Transfer flag set
    run(OP_SEF + 6'h07, 0, 0, 0, 0);                // Set interrupt flag
    status_register(8'hc9);                                    // Only I changed
    run(OP_CLF, 0, 0, 0, 0);                        // Clear carry
    status_register(8'hc8);                                    // Only C changed
    run(OP_ROR, 5, 0, 0, 0);                        // Rotate right
    rd(OFS_GPR + 8'h14, rv);
    chk(rv, 32'h25);                                // Old carry into bit 7
    status_register(8'hc0);                                    // Flags from result
    go(32'(OP_STD) | (32'h5 << F_RR) | (32'h3 << F_Q) | (32'h1 << F_PTR));
    chk({seen_addr, seen_data}, 32'h010325);        // Y plus offset
    rd(OFS_GPR + 8'h70, rv);
    chk(rv, 32'h00);                                // Y untouched
    run(OP_PUSH, 5, 0, 0, 0);                       // Push
    chk({seen_addr, seen_data}, 32'h000025);        // Old SP address
    rd(OFS_SP, rv);
    chk(rv, 32'hffff);                              // SP moved down
    run(OP_POP, 6, 0, 0, 0);                        // Pop into r6
    rd(OFS_GPR + 8'h18, rv);
    chk(rv, 32'h3c);                                // Memory byte landed
    rd(OFS_SP, rv);
    chk(rv, 32'h0000);                              // SP back up
    run(OP_OUT, 5, 0, 0, 0);                        // Port out
    chk({24'h0, seen_io}, 32'h25);                  // Register on I/O
    run(OP_IN, 7, 0, 0, 0);                         // Port
    rd(OFS_GPR + 8'h1c, rv);
    chk(rv, 32'h10);                                // I/O into r7
    run(OP_ASR, 5, 0, 0, 0);                        // Arithmetic shift
    rd(OFS_GPR + 8'h14, rv);
    chk(rv, 32'h12);                                // Sign kept
    status_register(8'hc9);                                    // Carry and V set
    run(OP_BLD, 6, 0, 0, 0);                        // Transfer to bit zero
    rd(OFS_GPR + 8'h18, rv);
    chk(rv, 32'h3d);                                // Bit zero from T
    run(OP_FLAG_SET_INDEXED, 0, 5, 0, 0);                       // Indexed set
    status_register(8'he9);                                    // H added
    run(OP_FLAG_CLEAR_INDEXED, 0, 7, 0, 0);                       // Indexed clear
    status_register(8'h69);                                    // I removed
    run(OP_LSR, 7, 0, 0, 0);                        // Logical right
    rd(OFS_GPR + 8'h1c, rv);
    chk(rv, 32'h08);                                // Zero into bit seven
    status_register(8'h60);                                    // All four clear
    run(OP_LPM, 3, 0, 0, 0);                        // Plain form into r0
    rd(OFS_GPR, rv);
    chk(rv, 32'h5a);                                // Low byte at even Z
    chk(32'(n_done), 32'(n_instr));                 // One done pulse each
    summarize();
  end
endmodule

`default_nettype wire
